// [logic/queue_index_and_event_base_regs.v]
// Command queue index, event queue base and event interrupt address registers with APB access
// Behaviour
// [RULE1] On a command error, store the reason first, raise the error flag next cycle.
// [RULE2] Reason field content is meaningless while the error flag is clear.
// [RULE3] Read index splits at queue size log: wrap flag above, index below.
// [RULE4] Each consumed command moves the read index to the next slot.
// [RULE5] Queue size log is clamped to maximum; bits above the wrap flag read zero. Only the read index is masked; the write index reads back all 20 stored bits.
// [RULE6] Incrementing wraps at configured size and toggles the wrap flag.
// [RULE7] Size log zero: one entry, wrap flag at bit zero.
// [RULE8] Size growth leaves upper bits undefined; shrink truncates the old value.
// [RULE9] Consumer write while disabled may load the reason field; here it loads.
// [RULE10] Read index may publish late but must publish in finite time.
// [RULE11] Error holds the read index on the bad command until acknowledged.
// [RULE12] Enable changes never clear the error; errors arise only while enabled.
// [RULE13] Consumer index writable only with enable and its acknowledge both zero.
// [RULE14] Write index register is always readable and writable.
// [RULE15] Event base bit 62 is the write-allocate hint for event writes.
// [RULE16] Event base from bits 55:5, clipped to address size, aligned to queue size.
// [RULE17] Event log size reads as written, clamped for every functional use.
// [RULE18] Events are written only with event queue enabled and room available.
// [RULE19] Event base writes while enabled are ignored.
// [RULE20] Event base read-only when settings fixed, else writable only when disabled.
// [RULE21] Message address is bits 55:2; zero address sends no message.
// [RULE22] Message address writable only while interrupt enable and acknowledge are zero.
// [RULE23] Software advances the write index past the commands it added.
// [RULE24] Queue is full when indices match and wrap flags differ.
// [RULE25] A write index write prompts a queue check when enabled and error-free.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "queue_regs_map.vh"

module queue_index_and_event_base_regs #(
	parameter queue_settings_fixed = 0,
	parameter [63:0] preset_evq_base = `RST_EVQ_BASE
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	output wire cmd_work_pending,
	output reg [19:0] cmd_slot,
	input wire cmd_consumed,
	input wire cmd_error,
	input wire [6:0] cmd_error_reason,
	input wire event_valid,
	input wire event_room,
	output wire event_write,
	output reg [55:0] event_queue_addr,
	output reg write_allocate_hint,
	output reg [55:0] msi_address,
	output reg msi_send_enable
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [2:0] control_reg_zero;
reg [2:0] enable_ack_reg;
reg [4:0] cmdq_log_field;
reg cmd_queue_error_flag;
reg err_arm;
reg [19:0] wr_index;
reg [19:0] rd_index;
reg [6:0] err_reason;
reg [63:0] event_queue_base;
reg [53:0] msi_addr_field;
reg work_kick;

wire cmd_queue_enable = control_reg_zero[`BIT_CMDQ_EN];
wire event_queue_enable = control_reg_zero[`BIT_EVQ_EN];
wire event_irq_enable = control_reg_zero[`BIT_EVIRQ_EN];

// ----------------------------------------
// Bus decode
// ----------------------------------------
wire wr_strobe = psel & penable & pwrite;
wire setup = psel & ~penable;
assign pready = 1'b1;

// ----------------------------------------
// Write guards
// ----------------------------------------
wire cmdq_idle = ~cmd_queue_enable & ~enable_ack_reg[`BIT_CMDQ_EN];
wire evq_idle = ~event_queue_enable & ~enable_ack_reg[`BIT_EVQ_EN];
wire evirq_idle = ~event_irq_enable & ~enable_ack_reg[`BIT_EVIRQ_EN];
wire rd_writable = cmdq_idle; // RULE13
wire base_writable = (queue_settings_fixed == 0) & evq_idle; // RULE20 RULE19
wire msi_writable = evirq_idle; // RULE22

// ----------------------------------------
// Write strobes
// ----------------------------------------
wire hit_ctrl = wr_strobe & (paddr == `OFS_CTRL);
wire hit_log = wr_strobe & (paddr == `OFS_CMDQ_LOG);
wire hit_err_ack = wr_strobe & (paddr == `OFS_GERR_ACK);
wire hit_wr = wr_strobe & (paddr == `OFS_CMDQ_WR);
wire hit_rd = wr_strobe & (paddr == `OFS_CMDQ_RD);
wire hit_base_lo = wr_strobe & (paddr == `OFS_EVQ_BASE_LO);
wire hit_base_hi = wr_strobe & (paddr == `OFS_EVQ_BASE_HI);
wire hit_msi_lo = wr_strobe & (paddr == `OFS_EVQ_MSI_LO);
wire hit_msi_hi = wr_strobe & (paddr == `OFS_EVQ_MSI_HI);

// ----------------------------------------
// Queue size arithmetic
// ----------------------------------------
// Stored log size reads back as written; only its use is clamped
wire [4:0] queue_size_log = (cmdq_log_field > `MAX_CMDQ_LOG) ? `MAX_CMDQ_LOG : cmdq_log_field; // RULE5
wire [19:0] wrap_bit = 20'h00001 << queue_size_log; // RULE3 RULE7
wire [19:0] low_mask = wrap_bit - 20'h00001;
wire [19:0] field_mask = low_mask | wrap_bit;
// Stored bits above the flag stay put until a consume clears them; masking gives truncation on shrink
wire [19:0] rd_view = rd_index & field_mask; // RULE5 RULE8
wire [19:0] wr_view = wr_index & field_mask;
wire queue_empty = (rd_view == wr_view);
wire queue_full = ((rd_view & low_mask) == (wr_view & low_mask)) &
	((rd_view & wrap_bit) != (wr_view & wrap_bit)); // RULE24
// Full queue has equal indices but differing flags; it still holds work
wire has_work = queue_full | ~queue_empty;

// Wrap toggles the flag and restarts the index at zero
reg [19:0] next_rd;
always @* begin
	if ((rd_index & low_mask) == low_mask) begin
		next_rd = (rd_index & wrap_bit) ^ wrap_bit; // RULE6 RULE7
	end else begin
		next_rd = (rd_index & wrap_bit) | ((rd_index & low_mask) + 20'h00001); // RULE4
	end
end

// ----------------------------------------
// Command consume
// ----------------------------------------
wire running = cmd_queue_enable & ~cmd_queue_error_flag & ~err_arm; // RULE11
assign cmd_work_pending = running & work_kick & has_work;
wire take_consume = cmd_work_pending & cmd_consumed & ~cmd_error;
wire take_error = cmd_work_pending & cmd_error; // RULE12

// ----------------------------------------
// Event queue
// ----------------------------------------
wire [4:0] evq_log = (event_queue_base[4:0] > `MAX_EVQ_LOG) ? `MAX_EVQ_LOG : event_queue_base[4:0]; // RULE17
wire [6:0] evq_align = {2'b00, evq_log} + 7'd`EVQ_ENTRY_LOG;
wire [63:0] align_mask = ~((64'h1 << evq_align) - 64'h1);
wire [63:0] oas_mask = (64'h1 << `PHYS_ADDR_BITS) - 64'h1;
wire [55:0] evq_addr_eff = event_queue_base[55:0] & align_mask[55:0] & oas_mask[55:0]; // RULE16
wire [55:0] msi_addr_eff = {msi_addr_field, 2'b00} & oas_mask[55:0]; // RULE21
assign event_write = event_valid & event_queue_enable & event_room; // RULE18

// ----------------------------------------
// Control and acknowledge
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		control_reg_zero <= 3'h0;
	end else if (hit_ctrl) begin
		control_reg_zero <= pwdata[2:0];
	end
end

// Acknowledge trails the enables by one cycle
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		enable_ack_reg <= 3'h0;
	end else begin
		enable_ack_reg <= control_reg_zero;
	end
end

// ----------------------------------------
// Queue size setting
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cmdq_log_field <= 5'h00;
	end else if (hit_log && cmdq_idle) begin
		cmdq_log_field <= pwdata[4:0];
	end
end

// ----------------------------------------
// Command queue indices
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		wr_index <= 20'h00000;
	end else if (hit_wr) begin
		wr_index <= pwdata[`IDX_HI:0]; // RULE14 RULE23
	end
end

// Kick survives until the queue drains so no work is missed
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		work_kick <= 1'b0;
	end else if (hit_wr && running) begin
		work_kick <= 1'b1; // RULE25
	end else if (!has_work) begin
		work_kick <= 1'b0;
	end
end

// Published every consume, so freed space shows at once
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		rd_index <= 20'h00000;
	end else if (take_consume) begin
		rd_index <= next_rd; // RULE4 RULE10
	end else if (hit_rd && rd_writable) begin
		rd_index <= pwdata[`IDX_HI:0]; // RULE13
	end
end

// ----------------------------------------
// Command error
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		err_reason <= 7'h00;
	end else if (take_error) begin
		err_reason <= cmd_error_reason; // RULE1
	end else if (hit_rd && rd_writable) begin
		err_reason <= pwdata[`ERR_HI:`ERR_LO]; // RULE9
	end
end

// Reason lands one cycle before the flag rises
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		err_arm <= 1'b0;
	end else begin
		err_arm <= take_error;
	end
end

// Raise wins over an acknowledge landing in the same cycle
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cmd_queue_error_flag <= 1'b0;
	end else if (err_arm) begin
		cmd_queue_error_flag <= 1'b1; // RULE1
	end else if (hit_err_ack && pwdata[`BIT_CMD_QUEUE_ERROR_FLAG]) begin
		cmd_queue_error_flag <= 1'b0; // RULE11 RULE12
	end
end

// ----------------------------------------
// Event queue base and message address
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		event_queue_base <= preset_evq_base;
	end else begin
		if (hit_base_lo && base_writable) begin
			event_queue_base[31:0] <= pwdata;
		end
		if (hit_base_hi && base_writable) begin
			event_queue_base[63:32] <= {1'b0, pwdata[`WA_BIT_HI:0]}; // RULE15
		end
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		msi_addr_field <= 54'h0;
	end else begin
		if (hit_msi_lo && msi_writable) begin
			msi_addr_field[29:0] <= pwdata[31:`MSI_ADDR_LO];
		end
		if (hit_msi_hi && msi_writable) begin
			msi_addr_field[53:30] <= pwdata[23:0];
		end
	end
end

// ----------------------------------------
// Registered outputs
// ----------------------------------------
// Slot follows the read index one cycle late
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cmd_slot <= 20'h00000;
	end else begin
		cmd_slot <= rd_view & low_mask; // RULE3
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		event_queue_addr <= 56'h0;
	end else begin
		event_queue_addr <= evq_addr_eff; // RULE16
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		write_allocate_hint <= 1'b0;
	end else begin
		write_allocate_hint <= event_queue_base[62]; // RULE15
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		msi_address <= 56'h0;
	end else begin
		msi_address <= msi_addr_eff; // RULE21
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		msi_send_enable <= 1'b0;
	end else begin
		msi_send_enable <= event_irq_enable & (msi_addr_eff != 56'h0); // RULE21
	end
end

// ----------------------------------------
// Read data, captured in the setup cycle
// ----------------------------------------
reg [31:0] next_rdata;
reg next_err;
always @* begin
	next_rdata = `RST_WORD;
	next_err = 1'b0;
	if (paddr == `OFS_CTRL) begin
		next_rdata = {29'h0, control_reg_zero};
	end else if (paddr == `OFS_CTRL_ACK) begin
		next_rdata = {29'h0, enable_ack_reg};
	end else if (paddr == `OFS_CMDQ_LOG) begin
		next_rdata = {27'h0, cmdq_log_field};
	end else if (paddr == `OFS_GERR) begin
		next_rdata = {31'h0, cmd_queue_error_flag};
	end else if (paddr == `OFS_GERR_ACK) begin
		next_rdata = `RST_WORD;
	end else if (paddr == `OFS_CMDQ_WR) begin
		next_rdata = {12'h000, wr_index}; // RULE14
	end else if (paddr == `OFS_CMDQ_RD) begin
		next_rdata = {1'b0, err_reason, 4'h0, rd_view}; // RULE2 RULE5
	end else if (paddr == `OFS_EVQ_BASE_LO) begin
		next_rdata = event_queue_base[31:0]; // RULE17
	end else if (paddr == `OFS_EVQ_BASE_HI) begin
		next_rdata = {1'b0, event_queue_base[62], 6'h00, event_queue_base[55:32]};
	end else if (paddr == `OFS_EVQ_MSI_LO) begin
		next_rdata = {msi_addr_field[29:0], 2'b00};
	end else if (paddr == `OFS_EVQ_MSI_HI) begin
		next_rdata = {8'h00, msi_addr_field[53:30]};
	end else begin
		next_err = 1'b1;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= `RST_WORD;
	end else if (setup) begin
		prdata <= next_rdata;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pslverr <= 1'b0;
	end else if (setup) begin
		pslverr <= next_err;
	end else if (!psel) begin
		pslverr <= 1'b0;
	end
end

endmodule // queue_index_and_event_base_regs

// [logic/queue_regs_map.vh]
// Register offsets, field positions and reset values of the queue register bank
`ifndef QUEUE_REGS_MAP_VH
`define QUEUE_REGS_MAP_VH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define OFS_CTRL 12'h020
`define OFS_CTRL_ACK 12'h024
`define OFS_CMDQ_LOG 12'h028
`define OFS_GERR 12'h060
`define OFS_GERR_ACK 12'h064
`define OFS_CMDQ_WR 12'h098
`define OFS_CMDQ_RD 12'h09c
`define OFS_EVQ_BASE_LO 12'h0a0
`define OFS_EVQ_BASE_HI 12'h0a4
`define OFS_EVQ_MSI_LO 12'h0b0
`define OFS_EVQ_MSI_HI 12'h0b4
// ----------------------------------------
// Fields
// ----------------------------------------
`define BIT_CMDQ_EN 0
`define BIT_EVQ_EN 1
`define BIT_EVIRQ_EN 2
`define BIT_CMD_QUEUE_ERROR_FLAG 0
`define ERR_HI 30
`define ERR_LO 24
`define IDX_HI 19
`define WA_BIT_HI 30
`define EVQ_ADDR_LO 5
`define MSI_ADDR_LO 2
`define EVQ_ENTRY_LOG 5
// ----------------------------------------
// Limits and reset values
// ----------------------------------------
`define MAX_CMDQ_LOG 5'd19
`define MAX_EVQ_LOG 5'd19
`define PHYS_ADDR_BITS 7'd48
`define RST_EVQ_BASE 64'h0000000000000000
`define RST_WORD 32'h00000000
`endif

// [test/cmd_consumer.sv]
// Command engine model: consumes slowly, fails on a chosen slot
`timescale 1ns/1ns
module cmd_consumer (
	input wire pclk,
	input wire presetn,
	input wire cmd_work_pending,
	input wire [19:0] cmd_slot,
	input wire fail_en,
	input wire [1:0] fail_slot,
	output reg cmd_consumed,
	output reg cmd_error,
	output reg [6:0] cmd_error_reason
);
	reg [1:0] gap;
	// One pulse per four cycles so the slot output has settled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap <= 2'h0;
			cmd_consumed <= 1'b0;
			cmd_error <= 1'b0;
			cmd_error_reason <= 7'h00;
		end else begin
			gap <= gap + 2'h1;
			cmd_consumed <= cmd_work_pending && gap == 2'h0 && !(fail_en && cmd_slot[1:0] == fail_slot);
			cmd_error <= cmd_work_pending && gap == 2'h0 && fail_en && cmd_slot[1:0] == fail_slot;
			cmd_error_reason <= 7'h2a;
		end
	end
endmodule // cmd_consumer

// [test/queue_index_and_event_base_regs_tb_top.sv]
// Testbench for the queue register bank
`timescale 1ns/1ns
`include "queue_regs_map.vh"
module queue_index_and_event_base_regs_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, rd;
	logic event_valid = 1'b0, event_room = 1'b0, fail_en = 1'b0;
	wire [31:0] prdata;
	wire pready, pslverr, cmd_work_pending, cmd_consumed, cmd_error, event_write, write_allocate_hint, msi_send_enable;
	wire [19:0] cmd_slot;
	wire [6:0] cmd_error_reason;
	wire [55:0] event_queue_addr, msi_address;
	int n_errors = 0, samples_checked = 0;
	always #2 pclk = ~pclk;
	queue_index_and_event_base_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cmd_work_pending, .cmd_slot, .cmd_consumed, .cmd_error, .cmd_error_reason,
		.event_valid, .event_room, .event_write, .event_queue_addr, .write_allocate_hint, .msi_address,
		.msi_send_enable);
	cmd_consumer partner (.pclk, .presetn, .cmd_work_pending, .cmd_slot, .fail_en, .fail_slot(2'h2),
		.cmd_consumed, .cmd_error, .cmd_error_reason);
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk({32'h0, rd & m}, {32'h0, e});
	endtask
	task automatic drain;
		int i;
		for (i = 0; i < 40 && cmd_work_pending !== 1'b1; i++) @(posedge pclk);
		chk(cmd_work_pending, 1'b1);
		for (i = 0; i < 60 && cmd_work_pending !== 1'b0; i++) @(posedge pclk);
		repeat (4) @(posedge pclk);
		chk(cmd_work_pending, 1'b0);
	endtask
	task automatic s_size;
		xfer(1'b1, `OFS_CTRL, 32'h0);
		xfer(1'b1, `OFS_CMDQ_LOG, 32'h1);
		rchk(`OFS_CMDQ_RD, 32'h000fffff, 32'h3);
		xfer(1'b1, `OFS_CMDQ_LOG, 32'h0);
		rchk(`OFS_CMDQ_RD, 32'h000fffff, 32'h1);
		xfer(1'b1, `OFS_CMDQ_LOG, 32'h1);
		xfer(1'b1, `OFS_CMDQ_RD, 32'h0);
		rchk(`OFS_CMDQ_RD, 32'h000fffff, 32'h0);
		xfer(1'b1, `OFS_CTRL, 32'h1);
		xfer(1'b1, `OFS_CMDQ_WR, 32'h2);
		drain;
		rchk(`OFS_CMDQ_RD, 32'h000fffff, 32'h2);
	endtask
	task automatic s_cmd;
		xfer(1'b0, 12'h0fc, 32'h0);
		chk({err, rd}, 33'h100000000);
		xfer(1'b1, `OFS_CMDQ_LOG, 32'h2);
		xfer(1'b1, `OFS_CMDQ_RD, 32'h000ffffb);
		rchk(`OFS_CMDQ_RD, 32'h000fffff, 32'h3);
		xfer(1'b1, `OFS_CTRL, 32'h1);
		xfer(1'b1, `OFS_CMDQ_WR, 32'h5);
		rchk(`OFS_CMDQ_WR, 32'hffffffff, 32'h5);
		drain;
		rchk(`OFS_CMDQ_RD, 32'h000fffff, 32'h5);
		xfer(1'b1, `OFS_CMDQ_RD, 32'h0);
		rchk(`OFS_CMDQ_RD, 32'h000fffff, 32'h5);
	endtask
	task automatic s_err;
		fail_en <= 1'b1;
		xfer(1'b1, `OFS_CMDQ_WR, 32'h7);
		drain;
		rchk(`OFS_CMDQ_RD, 32'h7f0fffff, 32'h2a000006);
		xfer(1'b1, `OFS_CTRL, 32'h0);
		xfer(1'b1, `OFS_CTRL, 32'h1);
		rchk(`OFS_GERR, 32'h1, 32'h1);
		fail_en <= 1'b0;
		xfer(1'b1, `OFS_GERR_ACK, 32'h1);
		drain;
		rchk(`OFS_CMDQ_RD, 32'h000fffff, 32'h7);
		rchk(`OFS_GERR, 32'h1, 32'h0);
	endtask
	task automatic s_evq;
		xfer(1'b1, `OFS_EVQ_BASE_LO, 32'h00001003);
		xfer(1'b1, `OFS_EVQ_BASE_HI, 32'h40ffffff);
		xfer(1'b1, `OFS_CTRL, 32'h3);
		rchk(`OFS_EVQ_BASE_LO, 32'hffffffff, 32'h00001003);
		chk(event_queue_addr, 64'h00ffff00001000);
		chk(write_allocate_hint, 1'b1);
		event_valid <= 1'b1;
		event_room <= 1'b1;
		@(posedge pclk);
		chk(event_write, 1'b1);
		xfer(1'b1, `OFS_EVQ_BASE_LO, 32'h0);
		rchk(`OFS_EVQ_BASE_LO, 32'hffffffff, 32'h00001003);
		xfer(1'b1, `OFS_CTRL, 32'h1);
		@(posedge pclk);
		chk(event_write, 1'b0);
		event_valid <= 1'b0;
	endtask
	task automatic s_msi;
		xfer(1'b1, `OFS_EVQ_MSI_LO, 32'h12345677);
		xfer(1'b1, `OFS_EVQ_MSI_HI, 32'h000000ab);
		xfer(1'b1, `OFS_CTRL, 32'h5);
		repeat (2) @(posedge pclk);
		chk({msi_send_enable, msi_address}, 57'h10000ab12345674);
		xfer(1'b1, `OFS_EVQ_MSI_LO, 32'h0);
		rchk(`OFS_EVQ_MSI_LO, 32'hffffffff, 32'h12345674);
		xfer(1'b1, `OFS_CTRL, 32'h1);
		xfer(1'b1, `OFS_EVQ_MSI_LO, 32'h0);
		xfer(1'b1, `OFS_EVQ_MSI_HI, 32'h0);
		xfer(1'b1, `OFS_CTRL, 32'h5);
		repeat (2) @(posedge pclk);
		chk(msi_send_enable, 1'b0);
	endtask
	task automatic report_and_stop;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		s_cmd;
		s_err;
		s_size;
		s_evq;
		s_msi;
		report_and_stop;
	end
	// Whole run needs well under 2000 cycles
	initial begin
		#40000;
		n_errors++;
		report_and_stop;
	end
endmodule // queue_index_and_event_base_regs_tb_top

// [test/queue_regs_sva.sv]
// Port assertions for the queue register bank
`timescale 1ns/1ns
`include "queue_regs_map.vh"
module queue_regs_sva (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire [11:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire cmd_work_pending,
	input wire [19:0] cmd_slot,
	input wire cmd_consumed,
	input wire cmd_error,
	input wire event_valid,
	input wire event_room,
	input wire event_write,
	input wire [55:0] event_queue_addr,
	input wire [55:0] msi_address,
	input wire msi_send_enable
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_always_a: assert property (pready) else $error("pready low");
	index_no_err_a: assert property (psel && penable && (paddr == `OFS_CMDQ_WR || paddr == `OFS_CMDQ_RD)
		|-> !pslverr) else $error("slave error on index register");
	event_gate_a: assert property (event_write |-> event_valid && event_room) else $error("event without room");
	msi_zero_a: assert property (msi_send_enable |-> msi_address != 56'h0) else $error("message to zero");
	msi_align_a: assert property (msi_address[1:0] == 2'h0) else $error("message address unaligned");
	evq_align_a: assert property (event_queue_addr[4:0] == 5'h00) else $error("event base unaligned");
	evq_clip_a: assert property (event_queue_addr[55:48] == 8'h00) else $error("event base above size");
	err_stop_a: assert property (cmd_error && cmd_work_pending |-> ##3 !cmd_work_pending)
		else $error("engine runs after error");
	slot_step_a: assert property (cmd_consumed && cmd_work_pending |-> ##3 cmd_slot != $past(cmd_slot, 3))
		else $error("slot did not advance");
endmodule // queue_regs_sva
bind queue_index_and_event_base_regs queue_regs_sva chk (.pclk, .presetn, .psel, .penable, .paddr, .pready,
	.pslverr, .cmd_work_pending, .cmd_slot, .cmd_consumed, .cmd_error, .event_valid, .event_room,
	.event_write, .event_queue_addr, .msi_address, .msi_send_enable);
